// ==== pbs_defines.svh ====
// pbs_defines.svh: offsets, fields, reset values and timing counts of the
// burst memory host controller.
// assumes: clk_sys at 25 MHz; included by bare name.
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PBS_REG_CMD      8'h00
`define PBS_REG_ADDR     8'h04
`define PBS_REG_CFG      8'h08
`define PBS_REG_WDATA    8'h0c
`define PBS_REG_RDATA    8'h10
`define PBS_REG_STATUS   8'h14

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define PBS_CFG_LC_LSB   0
`define PBS_CFG_WT_BIT   3
`define PBS_CFG_BL_LSB   4
`define PBS_CFG_RST      8'h32
`define PBS_DPD_REQ_BIT  4
`define PBS_ST_BUSY      0
`define PBS_ST_DPD       1
`define PBS_ST_RVALID    2
`define PBS_ST_ROWSTOP   3
`define PBS_ST_TRUNC     4
`define PBS_ST_PWRUP     5

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define PBS_OP_BRD       3'h1
`define PBS_OP_BWR       3'h2
`define PBS_OP_AWR       3'h3
`define PBS_OP_CFG       3'h4
`define PBS_OP_DPD_IN    3'h5
`define PBS_OP_DPD_OUT   3'h6

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PBS_CLK_MHZ          25
`define PBS_CLK_NS           40
`define PBS_T_DPD_ENTRY_US   150
`define PBS_T_DPD_EXIT_US    10
`define PBS_T_PWRUP_US       150
`define PBS_T_MAX_SEL_US     4
`define PBS_T_GAP_NS         5
`define PBS_DPD_ENTRY_CYC    (`PBS_T_DPD_ENTRY_US * `PBS_CLK_MHZ)
`define PBS_DPD_EXIT_CYC     (`PBS_T_DPD_EXIT_US * `PBS_CLK_MHZ)
`define PBS_PWRUP_CYC        (`PBS_T_PWRUP_US * `PBS_CLK_MHZ)
`define PBS_MAX_SEL_CYC      (`PBS_T_MAX_SEL_US * `PBS_CLK_MHZ)
`define PBS_GAP_CYC          ((`PBS_T_GAP_NS + `PBS_CLK_NS - 1) / `PBS_CLK_NS)
`define PBS_TICK_CYC         4
`define PBS_SEL_MARGIN       8

`endif

// ==== pbs_pkg.sv ====
// pbs_pkg.sv: types of the burst memory host controller.
// assumes: nothing beyond a SystemVerilog compiler.
package pbs_pkg;

  typedef enum logic [3:0] {
    ST_PWRUP, ST_IDLE, ST_ADDR, ST_LAT, ST_DATA, ST_AWR, ST_END,
    ST_DPD_HOLD, ST_DPD, ST_DPD_EXIT
  } pbs_state_e;

  typedef logic [15:0] pbs_word_t;

endpackage

// ==== pbs_buf2.sv ====
// pbs_buf2.sv: two-entry buffer with valid/ready on both sides.
// assumes: single clock domain, clock enable freezes all state.
`timescale 1ns/100ps
module pbs_buf2
  import pbs_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rstn,
  input  wire logic      clk_en,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire pbs_word_t in_data,
  output logic           out_valid,
  input  wire logic      out_ready,
  output pbs_word_t      out_data
);

  pbs_word_t  mem [0:1];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  logic       next_wr_ptr;
  logic       next_rd_ptr;
  logic [1:0] next_count;
  logic       push;
  logic       pop;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 2'd1;
    end else if (pop && !push) begin
      next_count = count - 2'd1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
      mem[0] <= 16'h0000;
      mem[1] <= 16'h0000;
    end else if (clk_en) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      if (push) begin
        mem[wr_ptr] <= in_data;
      end
    end
  end

endmodule

// ==== pbs_host.sv ====
// pbs_host.sv: host controller for a muxed address/data burst memory.
// assumes: memory clock is made here by a divider of clk_sys; memory
// wait and data inputs are asynchronous and are synchronised here.
//
// Notes on behaviour
// - chip enable high 150 us after power-down request
// - chip enable low 10 us to exit power-down
// - no command until 150 us after exit
// - read row stop ends select quickly
// - write row stop ends select quickly
// - deselect right after last burst write word
// - refresh opportunity every select window
// - deselect between async and burst operations
// - async write to fixed burst may stay selected
// - deselect gap between operations in sync mode
// - chip enable low never beyond 4 us, except the 10 us power-down exit pulse
`timescale 1ns/100ps
`include "pbs_defines.svh"
module pbs_host
  import pbs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             mem_clk,
  output logic             mem_ce_n,
  output logic             addr_valid_strobe_n,
  output logic             mem_we_n,
  output logic             mem_oe_n,
  output logic             mem_cre,
  output logic [4:0]       mem_addr_hi,
  input  wire logic [15:0] adq_in,
  output logic [15:0]      adq_out,
  output logic             adq_oe,
  input  wire logic        mem_wait_n
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic is_burst(input logic [2:0] op);
    return (op == `PBS_OP_BRD) || (op == `PBS_OP_BWR);
  endfunction

  function automatic logic is_cfg(input logic [2:0] op);
    return (op == `PBS_OP_CFG) || (op == `PBS_OP_DPD_IN);
  endfunction

  function automatic logic window_full(input logic [6:0] n);
    return 32'(n) >= `PBS_MAX_SEL_CYC - `PBS_SEL_MARGIN;
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  pbs_word_t adq_s1;
  pbs_word_t adq_s2;
  logic      wait_s1;
  logic      wait_s2;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      adq_s1  <= 16'h0000;
      adq_s2  <= 16'h0000;
      wait_s1 <= 1'b1;
      wait_s2 <= 1'b1;
    end else if (clk_en) begin
      adq_s1  <= adq_in;
      adq_s2  <= adq_s1;
      wait_s1 <= mem_wait_n;
      wait_s2 <= wait_s1;
    end
  end

  // ----------------------------------------------------------------------
  // read data buffer
  // ----------------------------------------------------------------------
  logic      buf_in_valid;
  logic      buf_in_ready;
  logic      buf_out_valid;
  logic      buf_pop;
  pbs_word_t buf_out_data;

  pbs_buf2 u_buf (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .clk_en    (clk_en),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (adq_s2),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  pbs_state_e  state, next_state;
  logic [1:0]  cnt, next_cnt;
  logic [2:0]  op, next_op;
  logic [2:0]  lat, next_lat;
  logic [3:0]  wcnt, next_wcnt;
  logic [6:0]  sel_cnt, next_sel_cnt;
  logic [11:0] timer, next_timer;
  logic [20:0] addr, next_addr;
  logic [7:0]  cfg, next_cfg;
  pbs_word_t   wdata, next_wdata;
  logic        row_stop, next_row_stop;
  logic        trunc, next_trunc;
  logic        clk_on, next_clk_on;
  logic        next_mem_clk;
  logic        next_ce_n;
  logic        next_adv_n;
  logic        next_we_n;
  logic        next_oe_n;
  logic        next_cre;
  logic        next_adq_oe;
  pbs_word_t   next_adq_out;
  logic [31:0] next_rdata;
  logic        tick;
  logic        run;
  logic        stall;
  logic        cmd_wr;
  logic        accept;
  logic [2:0]  lc;
  logic [3:0]  bl;

  assign lc          = cfg[`PBS_CFG_LC_LSB +: 3];
  assign bl          = cfg[`PBS_CFG_BL_LSB +: 4];
  assign mem_addr_hi = addr[20:16];
  assign buf_pop     = reg_rd && (reg_addr == `PBS_REG_RDATA) && buf_out_valid;

  always_comb begin
    next_state    = state;
    next_op       = op;
    next_lat      = lat;
    next_wcnt     = wcnt;
    next_timer    = timer;
    next_addr     = addr;
    next_cfg      = cfg;
    next_wdata    = wdata;
    next_row_stop = row_stop;
    next_trunc    = trunc;
    next_clk_on   = clk_on;
    next_ce_n     = mem_ce_n;
    next_adv_n    = addr_valid_strobe_n;
    next_we_n     = mem_we_n;
    next_oe_n     = mem_oe_n;
    next_cre      = mem_cre;
    next_adq_oe   = adq_oe;
    next_adq_out  = adq_out;
    buf_in_valid  = 1'b0;
    run   = (state == ST_ADDR) || (state == ST_LAT) || (state == ST_DATA) ||
            (state == ST_AWR) || (state == ST_END);
    // stop the memory clock while the read buffer is full
    stall = (state == ST_DATA) && (op == `PBS_OP_BRD) && !buf_in_ready;
    tick  = run && (cnt == 2'd3) && !stall;
    next_cnt = (run && !(cnt == 2'd3 && stall)) ? cnt + 2'd1 : cnt;

    // register writes
    cmd_wr = reg_wr && (reg_addr == `PBS_REG_CMD);
    if (reg_wr && reg_addr == `PBS_REG_ADDR) begin
      next_addr = reg_wdata[20:0];
    end
    if (reg_wr && reg_addr == `PBS_REG_CFG) begin
      next_cfg = reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == `PBS_REG_WDATA) begin
      next_wdata = reg_wdata[15:0];
    end
    accept = cmd_wr && (((state == ST_IDLE) && (reg_wdata[2:0] != 3'h0) &&
             (reg_wdata[2:0] < `PBS_OP_DPD_OUT)) ||
             ((state == ST_DPD) && (reg_wdata[2:0] == `PBS_OP_DPD_OUT)));

    // sel_cnt counts the select window of burst and async operations
    next_sel_cnt = (!mem_ce_n && run) ? sel_cnt + 7'd1 : 7'd0;

    unique case (state)
      ST_PWRUP: begin
        if (timer == 12'd0) begin
          next_state = ST_IDLE;
        end else begin
          next_timer = timer - 12'd1;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          next_op       = reg_wdata[2:0];
          next_row_stop = 1'b0;
          next_trunc    = 1'b0;
          next_ce_n     = 1'b0;
          next_adv_n    = 1'b0;
          next_adq_oe   = 1'b1;
          next_adq_out  = addr[15:0];
          next_we_n     = (reg_wdata[2:0] != `PBS_OP_BWR);
          next_cre      = is_cfg(reg_wdata[2:0]);
          next_clk_on   = is_burst(reg_wdata[2:0]);
          next_cnt      = 2'd0;
          next_state    = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (tick) begin
          next_adv_n = 1'b1;
          if (is_burst(op)) begin
            next_lat = lc;
            if (op == `PBS_OP_BRD) begin
              next_adq_oe = 1'b0;
              next_oe_n   = 1'b0;
            end
            next_state = ST_LAT;
          end else begin
            next_adq_out = wdata;
            next_we_n    = 1'b0;
            next_state   = ST_AWR;
          end
        end
      end
      ST_LAT: begin
        if (tick) begin
          if (lat <= 3'd1) begin
            next_wcnt    = 4'd0;
            next_adq_out = wdata;
            next_state   = ST_DATA;
          end else begin
            next_lat = lat - 3'd1;
          end
        end
      end
      ST_DATA: begin
        if (stall && window_full(sel_cnt)) begin
          // stalled burst still ends in time
          next_trunc = 1'b1;
          next_cnt   = 2'd0;
          next_state = ST_END;
        end else if (tick) begin
          if (!wait_s2) begin
            next_row_stop = 1'b1;
            next_state    = ST_END;
          end else begin
            buf_in_valid = (op == `PBS_OP_BRD);
            if (wcnt == bl) begin
              next_state = ST_END;
            end else if (window_full(sel_cnt)) begin
              next_trunc = 1'b1;
              next_state = ST_END;
            end else begin
              next_wcnt = wcnt + 4'd1;
            end
          end
        end
      end
      ST_AWR: begin
        if (tick) begin
          next_we_n  = 1'b1;
          next_state = ST_END;
        end
      end
      ST_END: begin
        // gap of one tick exceeds the gap time
        // unclocked deselect longer than 15 ns
        if (tick) begin
          if (op == `PBS_OP_DPD_IN && !wdata[`PBS_DPD_REQ_BIT]) begin
            next_timer = 12'(`PBS_DPD_ENTRY_CYC);
            next_state = ST_DPD_HOLD;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_DPD_HOLD: begin
        if (timer == 12'd0) begin
          next_state = ST_DPD;
        end else begin
          next_timer = timer - 12'd1;
        end
      end
      ST_DPD: begin
        if (accept) begin
          next_op    = reg_wdata[2:0];
          next_ce_n  = 1'b0;
          next_timer = 12'(`PBS_DPD_EXIT_CYC);
          next_state = ST_DPD_EXIT;
        end
      end
      ST_DPD_EXIT: begin
        if (timer == 12'd0) begin
          next_ce_n  = 1'b1;
          next_timer = 12'(`PBS_PWRUP_CYC);
          next_state = ST_PWRUP;
        end else begin
          next_timer = timer - 12'd1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // common release of select, strobes, clock and bus at burst or access end; address pins keep their value
    if (next_state == ST_END && state != ST_END) begin
      next_ce_n   = 1'b1;
      next_adv_n  = 1'b1;
      next_we_n   = 1'b1;
      next_oe_n   = 1'b1;
      next_cre    = 1'b0;
      next_adq_oe = 1'b0;
      next_clk_on = 1'b0;
    end
    next_mem_clk = next_clk_on && (next_cnt == 2'd1 || next_cnt == 2'd2);

    // read data stand one cycle after the strobe
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `PBS_REG_ADDR:   next_rdata = {11'h000, addr};
        `PBS_REG_CFG:    next_rdata = {24'h000000, cfg};
        `PBS_REG_WDATA:  next_rdata = {16'h0000, wdata};
        `PBS_REG_RDATA:  next_rdata = {16'h0000, buf_out_data};
        `PBS_REG_STATUS: begin
          next_rdata[`PBS_ST_BUSY]    = (state != ST_IDLE);
          next_rdata[`PBS_ST_DPD]     = (state == ST_DPD) || (state == ST_DPD_HOLD);
          next_rdata[`PBS_ST_RVALID]  = buf_out_valid;
          next_rdata[`PBS_ST_ROWSTOP] = row_stop;
          next_rdata[`PBS_ST_TRUNC]   = trunc;
          next_rdata[`PBS_ST_PWRUP]   = (state == ST_PWRUP) || (state == ST_DPD_EXIT);
        end
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state               <= ST_PWRUP;
      cnt                 <= 2'd3;
      op                  <= 3'h0;
      lat                 <= 3'd0;
      wcnt                <= 4'd0;
      sel_cnt             <= 7'd0;
      timer               <= 12'(`PBS_PWRUP_CYC);
      addr                <= 21'h000000;
      cfg                 <= `PBS_CFG_RST;
      wdata               <= 16'h0000;
      row_stop            <= 1'b0;
      trunc               <= 1'b0;
      clk_on              <= 1'b0;
      mem_clk             <= 1'b0;
      mem_ce_n            <= 1'b1;
      addr_valid_strobe_n <= 1'b1;
      mem_we_n            <= 1'b1;
      mem_oe_n            <= 1'b1;
      mem_cre             <= 1'b0;
      adq_oe              <= 1'b0;
      adq_out             <= 16'h0000;
      reg_rdata           <= 32'h0000_0000;
    end else if (clk_en) begin
      state               <= next_state;
      cnt                 <= next_cnt;
      op                  <= next_op;
      lat                 <= next_lat;
      wcnt                <= next_wcnt;
      sel_cnt             <= next_sel_cnt;
      timer               <= next_timer;
      addr                <= next_addr;
      cfg                 <= next_cfg;
      wdata               <= next_wdata;
      row_stop            <= next_row_stop;
      trunc               <= next_trunc;
      clk_on              <= next_clk_on;
      mem_clk             <= next_mem_clk;
      mem_ce_n            <= next_ce_n;
      addr_valid_strobe_n <= next_adv_n;
      mem_we_n            <= next_we_n;
      mem_oe_n            <= next_oe_n;
      mem_cre             <= next_cre;
      adq_oe              <= next_adq_oe;
      adq_out             <= next_adq_out;
      reg_rdata           <= next_rdata;
    end
  end

endmodule

// ==== pbs_host_monitor.sv ====
// pbs_host_monitor.sv: timing checks on the host controller pins.
// assumes: bound into pbs_host; clk_en held high.
`timescale 1ns/100ps
`include "pbs_defines.svh"
module pbs_host_monitor (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        mem_clk,
  input wire logic        mem_ce_n,
  input wire logic        addr_valid_strobe_n,
  input wire logic        mem_wait_n
);
  logic [8:0]  low_cnt, next_low_cnt;
  logic [11:0] quiet, next_quiet;
  logic        xit, next_xit, ent, next_ent, dph, next_dph, w_q;
  logic        cmd;
  assign cmd = reg_wr && reg_addr == `PBS_REG_CMD;
  // -------------------------------------------------------------
  // helper state
  // -------------------------------------------------------------
  always_comb begin
    next_low_cnt = mem_ce_n ? 9'h000 : low_cnt + 9'h001;
    next_quiet = (quiet != 12'h000) ? quiet - 12'h001 : 12'h000;
    next_xit = xit || (cmd && reg_wdata[2:0] == `PBS_OP_DPD_OUT);
    next_ent = ent || (cmd && reg_wdata[2:0] == `PBS_OP_DPD_IN);
    next_dph = !mem_ce_n && (dph || (mem_wait_n && !w_q));
    if (mem_ce_n && low_cnt != 9'h000) begin
      if (xit || ent) next_quiet = 12'(`PBS_PWRUP_CYC - 1);
      next_xit = 1'b0;
      next_ent = 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 9'h000;
      quiet <= 12'(`PBS_PWRUP_CYC - 1);
      xit <= 1'b0;
      ent <= 1'b0;
      dph <= 1'b0;
      w_q <= 1'b1;
    end else begin
      low_cnt <= next_low_cnt;
      quiet <= next_quiet;
      xit <= next_xit;
      ent <= next_ent;
      dph <= next_dph;
      w_q <= mem_wait_n;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_sel_window: assert property (!xit |-> low_cnt <= 9'h064)
    else $error("select held too long");
  a_quiet_time: assert property (quiet != 12'h000 |-> mem_ce_n)
    else $error("select during quiet time");
  a_exit_pulse: assert property (xit && mem_ce_n && low_cnt != 9'h000 |-> low_cnt >= 9'h0fa)
    else $error("exit pulse too short");
  a_gap_kept: assert property ($rose(mem_ce_n) |-> mem_ce_n [*4])
    else $error("deselect gap too short");
  a_clk_desel: assert property (mem_ce_n |-> !mem_clk)
    else $error("clock while deselected");
  a_row_stop: assert property (dph && $fell(mem_wait_n) |-> ##[1:7] mem_ce_n)
    else $error("late deselect on row stop");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_strobe_sel: assert property (!addr_valid_strobe_n |-> !mem_ce_n)
    else $error("strobe without select");
  c_row: cover property (dph && $fell(mem_wait_n));
  c_exit: cover property (xit && $rose(mem_ce_n));
  c_burst: cover property ($rose(mem_clk));
endmodule
bind pbs_host pbs_host_monitor mon_u (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mem_clk(mem_clk), .mem_ce_n(mem_ce_n), .addr_valid_strobe_n(addr_valid_strobe_n),
  .mem_wait_n(mem_wait_n));

// ==== pbs_mem_model.sv ====
// pbs_mem_model.sv: behavioural burst memory on the host pins.
// assumes: latency, length and row stop set by the bench.
`timescale 1ns/100ps
module pbs_mem_model
  import pbs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       mem_clk,
  input  wire logic       mem_ce_n,
  input  wire logic       mem_we_n,
  input  wire logic [2:0] lat_code,
  input  wire logic [4:0] burst_len,
  input  wire logic [4:0] stop_at,
  input  wire pbs_word_t  adq_out,
  input  wire logic       adq_oe,
  output pbs_word_t       adq_in,
  output logic            mem_wait_n,
  output logic [4:0]      wr_count,
  output pbs_word_t       wr_last,
  output logic            late_clk
);
  pbs_word_t base, drv, flt;
  logic      drive, is_wr, stp;
  int        n, k;
  // -------------------------------------------------------------
  // bus and burst engine
  // -------------------------------------------------------------
  assign adq_in = adq_oe ? adq_out : (drive ? drv : flt);
  initial begin
    flt = 16'h0000;
    late_clk = 1'b0;
    wr_count = 5'h00;
  end
  // released bus changes every cycle
  always @(posedge clk_sys) flt <= ~flt;
  always @(posedge mem_clk or posedge mem_ce_n) begin
    if (mem_ce_n) begin
      n = 0;
      drive <= 1'b0;
      mem_wait_n <= 1'b1;
    end else begin
      n = n + 1;
      k = n - int'(lat_code) - 2;
      stp = stop_at != 5'h00 && k == int'(stop_at);
      if (n == 1) begin
        is_wr = !mem_we_n;
        base = adq_in;
        wr_count <= 5'h00;
      end
      mem_wait_n <= !((k < 0 && n > 1) || stp);
      drive <= !is_wr && k >= 0 && k < int'(burst_len) && !stp;
      drv <= base + 16'(k);
      if (is_wr && k >= 0 && k < int'(burst_len)) begin
        wr_count <= wr_count + 5'h01;
        wr_last <= adq_in;
      end
      if (is_wr && k >= int'(burst_len)) late_clk <= 1'b1;
    end
  end
endmodule

// ==== pbs_host_tb_top.sv ====
// pbs_host_tb_top.sv: register-level test of the host controller.
// assumes: pbs_mem_model on the memory pins; clk_en held high.
`timescale 1ns/100ps
`include "pbs_defines.svh"
module pbs_host_tb_top
  import pbs_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, d, st;
  logic        mem_clk, mem_ce_n, strb_n, mem_we_n, adq_oe, mem_wait_n, late_clk;
  logic [4:0]  wr_count;
  logic [2:0]  lat_code = 3'h2;
  logic [4:0]  burst_len = 5'h04;
  logic [4:0]  stop_at = 5'h00;
  logic [7:0]  cfgs [3] = '{8'h32, 8'h1c, 8'h0a};
  pbs_word_t   adq_in, adq_out, wr_last;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          t0, k;
  // -------------------------------------------------------------
  // clock, parts, tasks
  // -------------------------------------------------------------
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  pbs_host dut_u (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_clk(mem_clk), .mem_ce_n(mem_ce_n), .addr_valid_strobe_n(strb_n),
    .mem_we_n(mem_we_n), .mem_oe_n(), .mem_cre(), .mem_addr_hi(), .adq_in(adq_in),
    .adq_out(adq_out), .adq_oe(adq_oe), .mem_wait_n(mem_wait_n));
  pbs_mem_model mem_u (.clk_sys(clk_sys), .mem_clk(mem_clk), .mem_ce_n(mem_ce_n),
    .mem_we_n(mem_we_n), .lat_code(lat_code), .burst_len(burst_len), .stop_at(stop_at),
    .adq_out(adq_out), .adq_oe(adq_oe), .adq_in(adq_in), .mem_wait_n(mem_wait_n),
    .wr_count(wr_count), .wr_last(wr_last), .late_clk(late_clk));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // status poll, bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int i;
    i = 0;
    do begin
      rd(`PBS_REG_STATUS);
      i++;
    end while ((d & m) !== v && i < 3000);
    if ((d & m) !== v) chk(d & m, v);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #1600000;
    n_errors++;
    tally_and_finish();
  end
  // -------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    t0 = cyc;
    rd(`PBS_REG_STATUS);
    chk(d, 32'h0000_0021);
    rd(`PBS_REG_CFG);
    chk(d, {24'h0, `PBS_CFG_RST});
    rd(8'h20);
    chk(d, 32'h0000_0000);
    poll(32'h1, 32'h0);
    chk({31'h0, cyc - t0 >= `PBS_PWRUP_CYC}, 32'h1);
    for (int o = 0; o < 8; o += 7) begin
      wr(`PBS_REG_CMD, 32'(o));
      rd(`PBS_REG_STATUS);
      chk(d & 32'h1, 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`PBS_REG_CFG, {24'h0, cfgs[i]});
      rd(`PBS_REG_CFG);
      chk(d, {24'h0, cfgs[i]});
      lat_code <= cfgs[i][2:0];
      burst_len <= 5'(cfgs[i][7:4]) + 5'h01;
      wr(`PBS_REG_ADDR, 32'h0001_1200 + 32'(i * 16));
      wr(`PBS_REG_CMD, {29'h0, `PBS_OP_BRD});
      for (int j = 0; j <= int'(cfgs[i][7:4]); j++) begin
        poll(32'h4, 32'h4);
        rd(`PBS_REG_RDATA);
        chk(d, 32'h1200 + 32'(i * 16 + j));
      end
      poll(32'h1, 32'h0);
      chk(d & 32'h1c, 32'h0);
    end
    wr(`PBS_REG_CFG, 32'h0000_0032);
    burst_len <= 5'h04;
    wr(`PBS_REG_WDATA, 32'h0000_beef);
    wr(`PBS_REG_CMD, {29'h0, `PBS_OP_BWR});
    poll(32'h1, 32'h0);
    chk({27'h0, wr_count}, 32'h4);
    chk({16'h0, wr_last}, 32'h0000_beef);
    wr(`PBS_REG_CMD, {29'h0, `PBS_OP_AWR});
    poll(32'h1, 32'h0);
    wr(`PBS_REG_CFG, 32'h0000_003a);
    stop_at <= 5'h02;
    wr(`PBS_REG_CMD, {29'h0, `PBS_OP_BRD});
    for (int j = 0; j < 2; j++) begin
      poll(32'h4, 32'h4);
      rd(`PBS_REG_RDATA);
      chk(d, 32'h1220 + 32'(j));
    end
    poll(32'h1, 32'h0);
    chk(d & 32'h0c, 32'h08);
    stop_at <= 5'h00;
    wr(`PBS_REG_CFG, 32'h0000_00f7);
    lat_code <= 3'h7;
    burst_len <= 5'h10;
    wr(`PBS_REG_ADDR, 32'h0000_3000);
    wr(`PBS_REG_CMD, {29'h0, `PBS_OP_BRD});
    // let the buffer fill so the window guard cuts the burst
    repeat (100) @(posedge clk_sys);
    k = 0;
    repeat (300) begin
      rd(`PBS_REG_STATUS);
      st = d;
      if (st[2] === 1'b1) begin
        rd(`PBS_REG_RDATA);
        chk(d, 32'h3000 + 32'(k));
        k++;
      end else if (st[0] === 1'b0) break;
    end
    chk(st & 32'h14, 32'h10);
    chk({31'h0, k < 16}, 32'h1);
    wr(`PBS_REG_WDATA, 32'h0000_0000);
    wr(`PBS_REG_CMD, {29'h0, `PBS_OP_DPD_IN});
    poll(32'h2, 32'h2);
    repeat (`PBS_DPD_ENTRY_CYC + 8) @(posedge clk_sys);
    t0 = cyc;
    wr(`PBS_REG_CMD, {29'h0, `PBS_OP_DPD_OUT});
    poll(32'h23, 32'h0);
    chk({31'h0, cyc - t0 >= `PBS_PWRUP_CYC + 250}, 32'h1);
    chk({31'h0, late_clk}, 32'h0);
    tally_and_finish();
  end
endmodule
